// ==== verilog/shc_pkg.sv ====
package shc_pkg;

  // ----------------------------------------
  // four-level strap codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    SHC_LVL_L = 2'h0,
    SHC_LVL_R = 2'h1,
    SHC_LVL_F = 2'h2,
    SHC_LVL_H = 2'h3
  } shc_level_t;

  // ----------------------------------------
  // status pin functions
  // ----------------------------------------
  typedef enum logic [1:0] {
    SHC_PIN_LOCK = 2'h0,
    SHC_PIN_CARRIER = 2'h1,
    SHC_PIN_INT = 2'h2
  } shc_pin_func_t;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    shc_level_t host;
    shc_level_t dir;
    shc_level_t mode;
    shc_level_t addrMaj;
    shc_level_t addrMin;
  } shc_straps_t;

  typedef struct packed {
    logic enable;
    logic invert;
    logic [1:0] vod;
    logic [1:0] dem;
  } shc_drv_t;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] SHC_REG_PAGE = 8'hFF;
  localparam logic [7:0] SHC_REG_MUTE_THR = 8'h03;
  localparam logic [7:0] SHC_REG_CABLE_IDX = 8'h25;
  localparam logic [7:0] SHC_REG_HOST_DRV = 8'h10;
  localparam logic [7:0] SHC_REG_STAT_CFG = 8'h04;
  localparam logic [7:0] SHC_REG_INT_MASK = 8'h05;
  localparam logic [7:0] SHC_REG_INT_STAT = 8'h06;
  localparam logic [7:0] SHC_REG_PIN_STAT = 8'h07;
  localparam logic [2:0] SHC_PAGE_SHARE = 3'h0;
  localparam logic [2:0] SHC_PAGE_CTLE = 3'h4;
  localparam logic [2:0] SHC_PAGE_IO = 3'h5;

  // host driver control fields
  localparam int SHC_HD_VOD_OVR = 0;
  localparam int SHC_HD_DEM_OVR = 1;
  localparam int SHC_HD_INVERT = 2;
  localparam int SHC_HD_VOD_LSB = 4;
  localparam int SHC_HD_DEM_LSB = 6;
  // status pin config fields
  localparam int SHC_SC_FUNC_LSB = 0;
  localparam int SHC_SC_CD_SRC = 2;

  // reset values
  localparam logic [2:0] SHC_PAGE_RST = 3'h0;
  localparam logic [5:0] SHC_MUTE_THR_RST = 6'h3F;
  localparam logic [7:0] SHC_HOST_DRV_RST = 8'h00;
  localparam logic [2:0] SHC_STAT_CFG_RST = 3'h0;
  localparam logic [6:0] SHC_INT_MASK_RST = 7'h00;

  // ----------------------------------------
  // interrupt sources
  // ----------------------------------------
  localparam int SHC_INT_W = 7;
  localparam int SHC_INT_LINE_LOSS = 0;
  localparam int SHC_INT_LINE_BACK = 1;
  localparam int SHC_INT_HOST_LOSS = 2;
  localparam int SHC_INT_HOST_BACK = 3;
  localparam int SHC_INT_EYE_LOW = 4;
  localparam int SHC_INT_LOCK_GAIN = 5;
  localparam int SHC_INT_LOCK_LOST = 6;

  // ----------------------------------------
  // host driver codes: 400/0, 570/-0.4, 660/-2.1, 830/-4.4
  // ----------------------------------------
  localparam logic [1:0] SHC_VOD_400 = 2'h0;
  localparam logic [1:0] SHC_VOD_570 = 2'h1;
  localparam logic [1:0] SHC_VOD_660 = 2'h2;
  localparam logic [1:0] SHC_VOD_830 = 2'h3;
  localparam logic [1:0] SHC_DEM_0P0 = 2'h0;
  localparam logic [1:0] SHC_DEM_0P4 = 2'h1;
  localparam logic [1:0] SHC_DEM_2P1 = 2'h2;
  localparam logic [1:0] SHC_DEM_4P4 = 2'h3;

  // ----------------------------------------
  // addressing and timing
  // ----------------------------------------
  localparam logic [6:0] SHC_SMB_ADDR_BASE = 7'h2D;
  localparam logic [6:0] SHC_SMB_ADDR_LAST = 7'h3C;
  localparam logic [1:0] SHC_STRAP_SETTLE_CYC = 2'h3;
  localparam logic [5:0] SHC_CABLE_IDX_MAX = 6'h37;

endpackage

// ==== verilog/shc_top.sv ====
// Behaviour
// - equalizer direction: host driver always enabled
// - host driver polarity inversion by register
// - equalizer direction: host strap sets amplitude, de-emphasis
// - driver direction: default 570 mVp-p, -0.4 dB
// - register override, amplitude and de-emphasis separate
// - driver direction: host strap sets input equalizer
// - open-drain status pin, function chosen by register
// - default function: pull low on lock
// - carrier function: low after adaptation, selectable input
// - interrupt function: low on unmasked event, seven masks
// - loss, eye-low and lock interrupt sources
// - interrupt sticky until status register read
// - cable boost index readable at 0x25
// - mute threshold at 0x03, same scale
// - interface strap: F SPI, L SMBus
// - SMBus mode repurposes shared serial pins
// - address straps form slave address 0x2D-0x3C
// - page 101 opens io configuration registers
`timescale 1ns/100ps
`default_nettype none

module shc_top
  import shc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // strap and select pins, four-level codes
  input wire shc_straps_t strapPins,
  input wire logic hostOutSelPin,
  // analog status
  input wire logic cdrLocked,
  input wire logic lineCarrier,
  input wire logic hostCarrier,
  input wire logic adaptDone,
  input wire logic lineLoss,
  input wire logic hostLoss,
  input wire logic eyeBelow,
  input wire logic [5:0] cableIdx,
  // register port from serial framing
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // open-drain status pin
  input wire logic statusPinIn,
  output logic statusPinOut,
  output logic statusPinOe,
  // host driver and mute
  output shc_drv_t hostDrv,
  output logic [1:0] hostInEq,
  output logic muteOut,
  // management interface setup
  output logic strapsValid,
  output logic smbusMode,
  output logic [6:0] smbusAddr
);

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  localparam int ASYNC_W = 9;
  localparam int STRAP_W = $bits(shc_straps_t);
  logic [ASYNC_W-1:0] asyncIn;
  logic [ASYNC_W-1:0] sync1_q;
  logic [ASYNC_W-1:0] sync2_q;
  logic [STRAP_W-1:0] strapS1_q;
  logic [STRAP_W-1:0] strapS2_q;

  assign asyncIn = {statusPinIn, hostOutSelPin, cdrLocked, lineCarrier, hostCarrier,
                    adaptDone, lineLoss, hostLoss, eyeBelow};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      strapS1_q <= '0;
      strapS2_q <= '0;
    end
    else
    begin
      sync1_q <= asyncIn;
      sync2_q <= sync1_q;
      strapS1_q <= strapPins;
      strapS2_q <= strapS1_q;
    end
  end

  wire selPinS = sync2_q[7];
  wire lockS = sync2_q[6];
  wire lineCdS = sync2_q[5];
  wire hostCdS = sync2_q[4];
  wire adaptS = sync2_q[3];
  wire lineLossS = sync2_q[2];
  wire hostLossS = sync2_q[1];
  wire eyeLowS = sync2_q[0];
  wire pinBackS = sync2_q[8];

  // ----------------------------------------
  // strap capture after reset release
  // ----------------------------------------
  typedef enum logic [2:0] {
    SHC_ST_SETTLE = 3'h1,
    SHC_ST_LATCH = 3'h2,
    SHC_ST_RUN = 3'h4
  } shc_cap_state_t;

  shc_cap_state_t capState_q;
  shc_cap_state_t capState_d;
  logic [1:0] settleCnt_q;
  shc_straps_t strapLat_q;

  // the strap levels are latched once; later pin changes are ignored
  always_comb
  begin
    capState_d = capState_q;
    unique case (capState_q)
      SHC_ST_SETTLE: if (settleCnt_q == SHC_STRAP_SETTLE_CYC) capState_d = SHC_ST_LATCH;
      SHC_ST_LATCH: capState_d = SHC_ST_RUN;
      SHC_ST_RUN: capState_d = SHC_ST_RUN;
      default: capState_d = SHC_ST_SETTLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      capState_q <= SHC_ST_SETTLE;
      settleCnt_q <= '0;
      strapLat_q <= '0;
    end
    else
    begin
      capState_q <= capState_d;
      if (capState_q == SHC_ST_SETTLE)
        settleCnt_q <= settleCnt_q + 2'h1;
      if (capState_q == SHC_ST_LATCH)
        strapLat_q <= shc_straps_t'(strapS2_q);
    end
  end

  wire strapsOk = (capState_q == SHC_ST_RUN);
  wire cdDir = (strapLat_q.dir == SHC_LVL_H);

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [2:0] page_q;
  logic [5:0] muteThr_q;
  logic [7:0] hostCtl_q;
  logic [2:0] statCfg_q;
  logic [SHC_INT_W-1:0] intMask_q;
  logic [SHC_INT_W-1:0] intStat_q;
  logic [SHC_INT_W-1:0] intStat_d;
  logic [SHC_INT_W-1:0] intSet;

  // io configuration page is only reachable with page code 101
  wire onIo = (page_q == SHC_PAGE_IO);
  wire onShare = (page_q == SHC_PAGE_SHARE);
  wire wrPage = regWrEn && (regAddr == SHC_REG_PAGE);
  wire wrMute = regWrEn && onIo && (regAddr == SHC_REG_MUTE_THR);
  wire wrHost = regWrEn && onIo && (regAddr == SHC_REG_HOST_DRV);
  wire wrStat = regWrEn && onShare && (regAddr == SHC_REG_STAT_CFG);
  wire wrMask = regWrEn && onShare && (regAddr == SHC_REG_INT_MASK);
  wire rdIntClr = regRdEn && onShare && (regAddr == SHC_REG_INT_STAT);

  function automatic logic [7:0] shc_read(input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    if (addr == SHC_REG_PAGE)
      v = {5'h00, page_q};
    else if (onIo && addr == SHC_REG_MUTE_THR)
      v = {2'h0, muteThr_q};
    else if (onIo && addr == SHC_REG_CABLE_IDX)
      v = {2'h0, cableIdx};
    else if (onIo && addr == SHC_REG_HOST_DRV)
      v = hostCtl_q;
    else if (onShare && addr == SHC_REG_STAT_CFG)
      v = {5'h00, statCfg_q};
    else if (onShare && addr == SHC_REG_INT_MASK)
      v = {1'b0, intMask_q};
    else if (onShare && addr == SHC_REG_INT_STAT)
      v = {1'b0, intStat_q};
    else if (onShare && addr == SHC_REG_PIN_STAT)
      v = {3'h0, pinBackS, cdDir, smbusMode, strapsValid, lockS};
    return v;
  endfunction

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      page_q <= SHC_PAGE_RST;
      muteThr_q <= SHC_MUTE_THR_RST;
      hostCtl_q <= SHC_HOST_DRV_RST;
      statCfg_q <= SHC_STAT_CFG_RST;
      intMask_q <= SHC_INT_MASK_RST;
      regRdData <= 8'h00;
    end
    else
    begin
      if (wrPage)
        page_q <= regWrData[2:0];
      if (wrMute)
        muteThr_q <= regWrData[5:0];
      if (wrHost)
        hostCtl_q <= regWrData;
      if (wrStat)
        statCfg_q <= regWrData[2:0];
      if (wrMask)
        intMask_q <= regWrData[SHC_INT_W-1:0];
      if (regRdEn)
        regRdData <= shc_read(regAddr);
    end
  end

  // ----------------------------------------
  // interrupt sources and sticky status
  // ----------------------------------------
  logic lockP_q;
  logic lineLossP_q;
  logic hostLossP_q;
  logic eyeLowP_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lockP_q <= 1'b0;
      lineLossP_q <= 1'b0;
      hostLossP_q <= 1'b0;
      eyeLowP_q <= 1'b0;
      intStat_q <= '0;
    end
    else
    begin
      lockP_q <= lockS;
      lineLossP_q <= lineLossS;
      hostLossP_q <= hostLossS;
      eyeLowP_q <= eyeLowS;
      intStat_q <= intStat_d;
    end
  end

  // loss sources follow the direction: line port for equalizer, host input for driver
  assign intSet[SHC_INT_LINE_LOSS] = !cdDir && lineLossS && !lineLossP_q;
  assign intSet[SHC_INT_LINE_BACK] = !cdDir && !lineLossS && lineLossP_q;
  assign intSet[SHC_INT_HOST_LOSS] = cdDir && hostLossS && !hostLossP_q;
  assign intSet[SHC_INT_HOST_BACK] = cdDir && !hostLossS && hostLossP_q;
  assign intSet[SHC_INT_EYE_LOW] = lockS && eyeLowS && !eyeLowP_q;
  assign intSet[SHC_INT_LOCK_GAIN] = lockS && !lockP_q;
  assign intSet[SHC_INT_LOCK_LOST] = !lockS && lockP_q;

  // an event in the clearing read's cycle survives the read
  assign intStat_d = strapsOk ? ((intStat_q & ~{SHC_INT_W{rdIntClr}}) | intSet) : '0;

  wire intActive = |(intStat_q & intMask_q);

  // ----------------------------------------
  // status pin
  // ----------------------------------------
  wire shc_pin_func_t pinFunc = shc_pin_func_t'(statCfg_q[SHC_SC_FUNC_LSB +: 2]);
  wire cdSel = statCfg_q[SHC_SC_CD_SRC] ? hostCdS : lineCdS;
  logic pullLow;

  always_comb
  begin
    unique case (pinFunc)
      SHC_PIN_CARRIER: pullLow = cdSel && adaptS;
      SHC_PIN_INT: pullLow = intActive;
      default: pullLow = lockS;
    endcase
  end

  // ----------------------------------------
  // host driver, input equalizer, mute
  // ----------------------------------------
  function automatic logic [1:0] shc_strap_code(input shc_level_t lvl);
    logic [1:0] c;
    c = 2'h0;
    unique case (lvl)
      SHC_LVL_H: c = 2'h0;
      SHC_LVL_F: c = 2'h1;
      SHC_LVL_R: c = 2'h2;
      SHC_LVL_L: c = 2'h3;
    endcase
    return c;
  endfunction

  wire [1:0] hostCode = shc_strap_code(strapLat_q.host);
  // codes share index order: 400/0, 570/-0.4, 660/-2.1, 830/-4.4
  wire [1:0] vodDflt = cdDir ? SHC_VOD_570 : hostCode;
  wire [1:0] demDflt = cdDir ? SHC_DEM_0P4 : hostCode;
  wire [1:0] vodSel = hostCtl_q[SHC_HD_VOD_OVR] ? hostCtl_q[SHC_HD_VOD_LSB +: 2] : vodDflt;
  wire [1:0] demSel = hostCtl_q[SHC_HD_DEM_OVR] ? hostCtl_q[SHC_HD_DEM_LSB +: 2] : demDflt;
  wire drvEn = cdDir ? selPinS : 1'b1;

  wire [6:0] addrCalc = SHC_SMB_ADDR_BASE +
                        {3'h0, strapLat_q.addrMaj, strapLat_q.addrMin};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      statusPinOut <= 1'b0;
      statusPinOe <= 1'b0;
      hostDrv <= '0;
      hostInEq <= 2'h0;
      muteOut <= 1'b0;
      strapsValid <= 1'b0;
      smbusMode <= 1'b0;
      smbusAddr <= 7'h00;
    end
    else
    begin
      // pin only ever pulls low; release lets the pull-up win
      statusPinOut <= 1'b0;
      statusPinOe <= strapsOk && pullLow;
      hostDrv.enable <= strapsOk && drvEn;
      hostDrv.invert <= hostCtl_q[SHC_HD_INVERT];
      hostDrv.vod <= vodSel;
      hostDrv.dem <= demSel;
      hostInEq <= cdDir ? hostCode : 2'h0;
      muteOut <= cableIdx > muteThr_q;
      strapsValid <= strapsOk;
      // reserved levels fall back to the spi framing, never smbus
      smbusMode <= strapsOk && (strapLat_q.mode == SHC_LVL_L);
      smbusAddr <= strapsOk ? addrCalc : 7'h00;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  chk_mute_compare: assert property (##1 muteOut == ($past(cableIdx) > $past(muteThr_q)))
    else $error("mute does not follow index versus threshold");
  chk_eq_enable: assert property (strapsOk && !cdDir |=> hostDrv.enable)
    else $error("host driver off in equalizer direction");
  chk_cd_default: assert property (strapsOk && cdDir && hostCtl_q[1:0] == 2'h0
    |=> hostDrv.vod == SHC_VOD_570 && hostDrv.dem == SHC_DEM_0P4)
    else $error("driver direction default wrong");
  chk_eq_decode: assert property (strapsOk && !cdDir && hostCtl_q[1:0] == 2'h0
    && strapLat_q.host == SHC_LVL_L |=> hostDrv.vod == SHC_VOD_830)
    else $error("host strap decode wrong");
  chk_int_sticky: assert property ((|intStat_q) && !rdIntClr |=> $past(intStat_q) == (intStat_q & $past(intStat_q)))
    else $error("interrupt bit lost without read");
  chk_int_release: assert property (rdIntClr && intSet == '0 ##1 intSet == '0 |-> ##1 !statusPinOe || pinFunc != SHC_PIN_INT)
    else $error("pin not released after status read");
  chk_lock_pin: assert property (strapsOk && pinFunc == SHC_PIN_LOCK && lockS |=> statusPinOe)
    else $error("lock not shown on status pin");
  chk_addr_range: assert property (strapsValid |-> smbusAddr >= SHC_SMB_ADDR_BASE && smbusAddr <= SHC_SMB_ADDR_LAST)
    else $error("slave address out of range");
  chk_strap_hold: assert property (strapsOk && $past(strapsOk) |-> $stable(strapLat_q))
    else $error("latched strap changed");
  chk_smbus_mode: assert property (strapsOk |=> smbusMode == (strapLat_q.mode == SHC_LVL_L))
    else $error("interface mode decode wrong");
endmodule
`default_nettype wire

// ==== bench/shc_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module shc_host_model
  import shc_pkg::*;
(
  // clock
  input wire logic clk,
  // register port toward the device
  output logic regWrEn,
  output logic regRdEn,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData
);
  // ----------------------------------------
  // idle bus
  // ----------------------------------------
  initial
  begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'hA5;
    regWrData = 8'h5A;
  end

  // ----------------------------------------
  // byte transfers, entered just after an edge
  // ----------------------------------------
  // serial framing modelled away; byte rate far below the bus ceiling
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    regAddr = addr;
    regWrData = data;
    regWrEn = 1'b1;
    @(posedge clk);
    #1;
    regWrEn = 1'b0;
    // released bus never repeats the last value
    regAddr = ~addr;
    regWrData = ~data;
    // one idle edge, so no signal is set twice in one step
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    regAddr = addr;
    regRdEn = 1'b1;
    @(posedge clk);
    #1;
    regRdEn = 1'b0;
    regAddr = ~addr;
    data = regRdData;
    @(posedge clk);
    #1;
  endtask

  // io configuration registers stay closed until their page is chosen
  task automatic page(input logic [2:0] pg);
    wr(SHC_REG_PAGE, {5'h00, pg});
  endtask
endmodule

`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none

module testbench
  import shc_pkg::*;
();
  logic clk, rst, hostOutSelPin, cdrLocked, lineCarrier, hostCarrier, adaptDone;
  logic lineLoss, hostLoss, eyeBelow, regWrEn, regRdEn;
  logic [5:0] cableIdx;
  logic [7:0] regAddr, regWrData, regRdData, d;
  shc_straps_t strapPins;
  shc_drv_t hostDrv;
  logic statusPinOut, statusPinOe, muteOut, strapsValid, smbusMode;
  logic [1:0] hostInEq;
  logic [6:0] smbusAddr;
  wire statusPin;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;

  // open-drain pin with pull-up
  assign statusPin = statusPinOe ? statusPinOut : 1'b1;

  typedef struct packed {
    shc_straps_t straps;
    logic sel;
    shc_drv_t drv;
    logic [1:0] inEq;
    logic smb;
    logic [6:0] addr;
  } shc_tb_row_t;

  // straps {host,dir,mode,maj,min}; board keeps mode at F or L
  shc_tb_row_t rows [6] = '{
    '{10'h300, 1'b0, 6'h20, 2'h0, 1'b1, 7'h2D},
    '{10'h225, 1'b1, 6'h25, 2'h0, 1'b0, 7'h00},
    '{10'h10B, 1'b0, 6'h2A, 2'h0, 1'b1, 7'h38},
    '{10'h00F, 1'b0, 6'h2F, 2'h0, 1'b1, 7'h3C},
    '{10'h1E0, 1'b1, 6'h25, 2'h2, 1'b0, 7'h00},
    '{10'h2CC, 1'b0, 6'h05, 2'h1, 1'b1, 7'h39}
  };

  shc_top u_shc_top (.clk(clk), .rst(rst), .strapPins(strapPins),
    .hostOutSelPin(hostOutSelPin), .cdrLocked(cdrLocked), .lineCarrier(lineCarrier),
    .hostCarrier(hostCarrier), .adaptDone(adaptDone), .lineLoss(lineLoss),
    .hostLoss(hostLoss), .eyeBelow(eyeBelow), .cableIdx(cableIdx), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .statusPinIn(statusPin), .statusPinOut(statusPinOut), .statusPinOe(statusPinOe),
    .hostDrv(hostDrv), .hostInEq(hostInEq), .muteOut(muteOut),
    .strapsValid(strapsValid), .smbusMode(smbusMode), .smbusAddr(smbusAddr));

  shc_host_model u_shc_host_model (.clk(clk), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // straps are only taken after a reset, so every row needs one
  task automatic power_up(input shc_straps_t s, input logic sel);
    int n;
    rst = 1'b1;
    strapPins = s;
    hostOutSelPin = sel;
    cyc(16);
    rst = 1'b0;
    n = 0;
    while (strapsValid !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    chk(strapsValid, 1'b1, "strapsValid");
    cyc(3);
  endtask

  // edge events reach the pin four cycles after the input (sync, detect, pin register); six leave margin
  task automatic int_hit(input int b);
    cyc(6);
    chk(statusPinOe, 1'b1, "intPin");
    u_shc_host_model.rd(SHC_REG_INT_STAT, d);
    chk(d, 8'h01 << b, "intStat");
    cyc(3);
    chk(statusPinOe, 1'b0, "intRelease");
  endtask

  // ----------------------------------------
  // clock and timeout
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {cdrLocked, lineCarrier, hostCarrier, adaptDone} = 4'h0;
    {lineLoss, hostLoss, eyeBelow} = 3'h0;
    cableIdx = 6'h00;
    foreach (rows[i])
    begin
      power_up(rows[i].straps, rows[i].sel);
      chk(hostDrv, rows[i].drv, "hostDrv");
      chk(hostInEq, rows[i].inEq, "hostInEq");
      chk(smbusMode, rows[i].smb, "smbusMode");
      if (rows[i].smb)
        chk(smbusAddr, rows[i].addr, "smbusAddr");
    end
    power_up(10'h300, 1'b0);
    strapPins = 10'h3FF;
    cyc(6);
    chk(smbusAddr, 7'h2D, "latchedAddr");
    chk(hostDrv, 6'h20, "latchedDrv");
    u_shc_host_model.page(SHC_PAGE_IO);
    cableIdx = 6'h37;
    u_shc_host_model.rd(SHC_REG_MUTE_THR, d);
    chk(d, 8'h3F, "muteThrRst");
    u_shc_host_model.wr(SHC_REG_CABLE_IDX, 8'h00);
    u_shc_host_model.rd(SHC_REG_CABLE_IDX, d);
    chk(d, 8'h37, "cableIdx");
    chk(muteOut, 1'b0, "muteMax");
    u_shc_host_model.wr(SHC_REG_MUTE_THR, 8'h20);
    chk(muteOut, 1'b1, "muteNewThr");
    cableIdx = 6'h20;
    cyc(3);
    chk(muteOut, 1'b0, "muteEqual");
    cableIdx = 6'h21;
    cyc(2);
    chk(muteOut, 1'b1, "muteAbove");
    u_shc_host_model.page(SHC_PAGE_SHARE);
    u_shc_host_model.wr(SHC_REG_MUTE_THR, 8'h3F);
    u_shc_host_model.rd(SHC_REG_CABLE_IDX, d);
    chk(d, 8'h00, "closedPage");
    u_shc_host_model.page(SHC_PAGE_IO);
    u_shc_host_model.rd(SHC_REG_MUTE_THR, d);
    chk(d, 8'h20, "thrKept");
    u_shc_host_model.wr(SHC_REG_HOST_DRV, 8'h31);
    cyc(2);
    chk(hostDrv, 6'h2C, "vodOvr");
    u_shc_host_model.wr(SHC_REG_HOST_DRV, 8'h82);
    cyc(2);
    chk(hostDrv, 6'h22, "demOvr");
    u_shc_host_model.wr(SHC_REG_HOST_DRV, 8'h04);
    cyc(2);
    chk(hostDrv, 6'h30, "invert");
    u_shc_host_model.page(SHC_PAGE_SHARE);
    cdrLocked = 1'b1;
    cyc(4);
    chk({statusPin, statusPinOe}, 2'h1, "lockPin");
    cdrLocked = 1'b0;
    cyc(4);
    chk(statusPinOe, 1'b0, "unlockPin");
    u_shc_host_model.wr(SHC_REG_STAT_CFG, 8'h01);
    lineCarrier = 1'b1;
    cyc(4);
    chk(statusPinOe, 1'b0, "cdAdapting");
    adaptDone = 1'b1;
    cyc(4);
    chk(statusPinOe, 1'b1, "cdLine");
    u_shc_host_model.wr(SHC_REG_STAT_CFG, 8'h05);
    cyc(4);
    chk(statusPinOe, 1'b0, "cdHostOff");
    hostCarrier = 1'b1;
    cyc(4);
    chk(statusPinOe, 1'b1, "cdHost");
    u_shc_host_model.wr(SHC_REG_STAT_CFG, 8'h02);
    u_shc_host_model.wr(SHC_REG_INT_MASK, 8'h00);
    u_shc_host_model.rd(SHC_REG_INT_STAT, d);
    chk(d, 8'h60, "lockEvents");
    cyc(3);
    chk(statusPinOe, 1'b0, "intIdle");
    u_shc_host_model.wr(SHC_REG_INT_MASK, 8'h01);
    lineLoss = 1'b1;
    int_hit(SHC_INT_LINE_LOSS);
    u_shc_host_model.wr(SHC_REG_INT_MASK, 8'h02);
    lineLoss = 1'b0;
    int_hit(SHC_INT_LINE_BACK);
    u_shc_host_model.wr(SHC_REG_INT_MASK, 8'h20);
    cdrLocked = 1'b1;
    int_hit(SHC_INT_LOCK_GAIN);
    u_shc_host_model.wr(SHC_REG_INT_MASK, 8'h10);
    eyeBelow = 1'b1;
    int_hit(SHC_INT_EYE_LOW);
    cdrLocked = 1'b0;
    cyc(6);
    chk(statusPinOe, 1'b0, "masked");
    u_shc_host_model.wr(SHC_REG_INT_MASK, 8'h40);
    int_hit(SHC_INT_LOCK_LOST);
    // driver direction: host input losses count, line losses do not
    power_up(10'h1E0, 1'b1);
    u_shc_host_model.rd(SHC_REG_PIN_STAT, d);
    chk(d, 8'h1A, "pinStat");
    u_shc_host_model.wr(SHC_REG_STAT_CFG, 8'h02);
    u_shc_host_model.wr(SHC_REG_INT_MASK, 8'h04);
    {lineLoss, hostLoss} = 2'h3;
    int_hit(SHC_INT_HOST_LOSS);
    u_shc_host_model.wr(SHC_REG_INT_MASK, 8'h08);
    {lineLoss, hostLoss} = 2'h0;
    int_hit(SHC_INT_HOST_BACK);
    end_sim();
  end
endmodule

`default_nettype wire
